// ===== hw/cfcs_pkg.sv
// Package for the channel filter configuration and self-test block.
// Assumes one host register port (channel address, data, write and read strobes).
package cfcs_pkg;

  // Channel register addresses
  localparam logic [7:0] ADDR_INTERP_M1  = 8'h91;
  localparam logic [7:0] ADDR_RS_SCALE   = 8'h92;
  localparam logic [7:0] ADDR_RSVD_A     = 8'h93;
  localparam logic [7:0] ADDR_C5_DECIM   = 8'h94;
  localparam logic [7:0] ADDR_C5_SCALE   = 8'h95;
  localparam logic [7:0] ADDR_RSVD_B     = 8'h96;
  localparam logic [7:0] ADDR_CF_DECIM   = 8'hA0;
  localparam logic [7:0] ADDR_CF_PHASE   = 8'hA1;
  localparam logic [7:0] ADDR_CF_TAPS    = 8'hA2;
  localparam logic [7:0] ADDR_CF_OFFSET  = 8'hA3;
  localparam logic [7:0] ADDR_CF_CTRL    = 8'hA4;
  localparam logic [7:0] ADDR_ST_I       = 8'hA5;
  localparam logic [7:0] ADDR_ST_Q       = 8'hA6;
  localparam logic [7:0] ADDR_ST_COUNT   = 8'hA7;
  localparam logic [7:0] ADDR_OUT_CTRL   = 8'hA9;

  // Resampling comb scale fields
  localparam int RS_EXP_INV_BIT = 11;
  localparam int RS_EXP_WT_BIT  = 10;
  localparam int RS_QUIET_LSB   = 5;
  localparam int RS_LOUD_LSB    = 0;
  localparam int SCALE_W        = 5;

  // Coefficient filter and output control fields
  localparam int CF_BYPASS_BIT  = 10;
  localparam int CF_SRC_BIT     = 9;
  localparam int CF_BANK_BIT    = 8;
  localparam int CF_COMEXP_BIT  = 7;
  localparam int CF_FORCE_BIT   = 6;
  localparam int CF_FMT_LSB     = 4;
  localparam int CF_OSCALE_LSB  = 0;
  localparam int MAP_BIT        = 9;
  localparam int WORD_BIT       = 5;

  // Output format codes
  localparam logic [1:0] FMT_FIXED = 2'h0;
  localparam logic [1:0] FMT_FP8   = 2'h1;

  // Reset values, signature seed and polynomial
  localparam logic [15:0] SIG_SEED  = 16'hFFFF;
  localparam logic [15:0] SIG_POLY  = 16'h1021;
  localparam logic [19:0] COUNT_RST = 20'h0_0000;

  // Exponent step weight in hundredths of a dB
  localparam int EXP_STEP_LO_CDB = 602;
  localparam int EXP_STEP_HI_CDB = 1202;

  typedef enum logic [1:0] {
    CFCS_ST_IDLE = 2'b00,
    CFCS_ST_RUN  = 2'b01,
    CFCS_ST_DONE = 2'b11
  } cfcs_state_e;

  // One sample of filter output
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } cfcs_iq_s;

  // Settings handed to the filter datapath
  typedef struct packed {
    logic [8:0]  interp_m1;
    logic        exp_invert;
    logic        exp_weight;
    logic [4:0]  rs_scale;
    logic [7:0]  c5_decim_m1;
    logic [4:0]  c5_scale;
    logic [7:0]  cf_decim_m1;
    logic [7:0]  cf_phase;
    logic [8:0]  cf_taps;
    logic [7:0]  cf_offset;
    logic [2:0]  cf_src_chan;
    logic        cf_bypass;
    logic        common_exp;
    logic        apply_scale;
    logic [1:0]  out_fmt;
    logic [3:0]  out_scale;
  } cfcs_cfg_s;

endpackage

// ===== hw/cfcs_top.sv
// Channel filter configuration registers, output buffer and self-test signatures.
// Assumes synchronous host strobes, and a filter datapath that reports filter starts
// and delivers I/Q words with valid/ready.
// Reserved and unused addresses are not stored; the host keeps them zero.
// Format arithmetic and saturation live in the datapath; only settings leave here.
//
// Contract
// - Interpolation register holds factor minus one, factors 1 to 512.
// - Scale bit 11 inverts input exponent polarity.
// - Scale bit 10 selects exponent step weight of 6.02 or 12.02 dB.
// - Scale register holds two 5-bit scales chosen by level indicator pin.
// - Fifth comb decimation register holds decimation minus one; host keeps 1 to 32.
// - Coefficient decimation register holds decimation minus one, up to 256.
// - Phase register may change anytime, applied at each filter start; only active_phase is shadowed, cfg.cf_phase follows the register at once.
// - Tap count equals tap register plus one.
// - Coefficient offset shadowed, applied only at next filter start; only active_offset is shadowed, cfg.cf_offset follows the register at once.
// - Bypass bit routes fifth comb output to self-test registers.
// - Control bit 9 selects own or partner channel comb output.
// - Control bit 8 selects coefficient memory half for host writes.
// - Common exponent bit shares one exponent from larger magnitude.
// - Force scale applies output scale in float modes, mantissas saturate.
// - Bits 5-4 select 12+4, 8+4 or fixed point output.
// - Format applies only for direct channel output, gain loop output fixed.
// - Bits 3-0 give output scale in fixed mode or when forced.
// - With map bit set, self-test registers present 16-bit output data.
// - Writing count register starts self-test over that many outputs.
// - With map bit clear, self-test registers work in signature mode.
`timescale 1ns/10ps

module cfcs_top #(
  parameter int CHANNEL = 0,
  parameter int COUNT_W = 20
) (
  input  wire logic                clock,
  input  wire logic                rst,
  // Host register port
  input  wire logic [7:0]          host_addr,
  input  wire logic [19:0]         host_wdata,
  input  wire logic                host_wr,
  input  wire logic                host_rd,
  output logic [19:0]              host_rdata,
  output logic                     host_rdata_valid,
  // Level indicator and output path selection
  input  wire logic                level_indicator_pin,
  input  wire logic                agc_path_sel,
  // Datapath side
  input  wire logic                filter_start,
  input  wire logic                comb_in_valid,
  output logic                     comb_in_ready,
  input  wire cfcs_pkg::cfcs_iq_s  comb_in,
  input  wire logic                cf_in_valid,
  output logic                     cf_in_ready,
  input  wire cfcs_pkg::cfcs_iq_s  cf_in,
  output cfcs_pkg::cfcs_cfg_s      cfg,
  output logic                     coefficient_memory_bank,
  output logic [7:0]               active_offset,
  output logic [7:0]               active_phase,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output cfcs_pkg::cfcs_iq_s       out_data,
  output logic                     selftest_busy
);

  // Register storage
  logic [8:0]         interp_reg;
  logic [11:0]        rs_scale_reg;
  logic [7:0]         c5_decim_reg;
  logic [4:0]         c5_scale_reg;
  logic [7:0]         cf_decim_reg;
  logic [7:0]         cf_phase_reg;
  logic [7:0]         cf_taps_reg;
  logic [7:0]         cf_offset_reg;
  logic [10:0]        cf_ctrl_reg;
  logic [9:0]         out_ctrl_reg;

  // Shadows, signatures and mapped capture
  logic [7:0]         offset_shadow_reg;
  logic [7:0]         phase_shadow_reg;
  logic [15:0]        sig_i_reg;
  logic [15:0]        sig_q_reg;
  logic [15:0]        map_i_reg;
  logic [15:0]        map_q_reg;
  logic [COUNT_W-1:0] count_reg;

  // Read answer and self-test sequencer
  logic [19:0]        rdata_reg;
  logic               rvalid_reg;
  cfcs_pkg::cfcs_state_e state_reg;
  cfcs_pkg::cfcs_state_e state_next;

  // Two-entry buffer
  cfcs_pkg::cfcs_iq_s buf_mem [2];
  logic               wptr_reg;
  logic               rptr_reg;
  logic [1:0]         fill_reg;

  // Write decode, one function shared by every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire wr_interp = host_wr && hit(host_addr, cfcs_pkg::ADDR_INTERP_M1);
  wire wr_scale  = host_wr && hit(host_addr, cfcs_pkg::ADDR_RS_SCALE);
  wire wr_c5dec  = host_wr && hit(host_addr, cfcs_pkg::ADDR_C5_DECIM);
  wire wr_c5scl  = host_wr && hit(host_addr, cfcs_pkg::ADDR_C5_SCALE);
  wire wr_cfdec  = host_wr && hit(host_addr, cfcs_pkg::ADDR_CF_DECIM);
  wire wr_phase  = host_wr && hit(host_addr, cfcs_pkg::ADDR_CF_PHASE);
  wire wr_taps   = host_wr && hit(host_addr, cfcs_pkg::ADDR_CF_TAPS);
  wire wr_offset = host_wr && hit(host_addr, cfcs_pkg::ADDR_CF_OFFSET);
  wire wr_ctrl   = host_wr && hit(host_addr, cfcs_pkg::ADDR_CF_CTRL);
  wire wr_count  = host_wr && hit(host_addr, cfcs_pkg::ADDR_ST_COUNT);
  wire wr_outc   = host_wr && hit(host_addr, cfcs_pkg::ADDR_OUT_CTRL);

  // Reads have no side effects, so only writes are decoded here

  // Control fields
  wire       map_mode   = out_ctrl_reg[cfcs_pkg::MAP_BIT];
  wire       bypass     = cf_ctrl_reg[cfcs_pkg::CF_BYPASS_BIT];
  wire [1:0] fmt        = cf_ctrl_reg[cfcs_pkg::CF_FMT_LSB +: 2];
  wire       force_sc   = cf_ctrl_reg[cfcs_pkg::CF_FORCE_BIT];
  wire [3:0] oscale     = cf_ctrl_reg[cfcs_pkg::CF_OSCALE_LSB +: 4];
  wire       common_exp = cf_ctrl_reg[cfcs_pkg::CF_COMEXP_BIT];
  // Gain loop output is always fixed point
  wire [1:0] eff_fmt    = agc_path_sel ? cfcs_pkg::FMT_FIXED : fmt;
  wire       apply_sc   = (eff_fmt == cfcs_pkg::FMT_FIXED) || force_sc;

  // Partner channel: 0<-1, 1<-0, 2,3<-1, 4<-5, 5<-4, 6,7<-5
  // Pairs of channels share coefficient filters for wider bandwidths
  localparam logic [2:0] CH = 3'(CHANNEL);
  wire [2:0] partner = {CH[2], 1'b0, (CH[1:0] == 2'b01) ? 1'b0 : 1'b1};
  wire [2:0] src_chan = cf_ctrl_reg[cfcs_pkg::CF_SRC_BIT] ? partner : CH;

  // Settings to the datapath
  always_comb
  begin
    cfg.interp_m1   = interp_reg;
    cfg.exp_invert  = rs_scale_reg[cfcs_pkg::RS_EXP_INV_BIT];
    cfg.exp_weight  = rs_scale_reg[cfcs_pkg::RS_EXP_WT_BIT];
    cfg.rs_scale    = level_indicator_pin
                      ? rs_scale_reg[cfcs_pkg::RS_LOUD_LSB +: cfcs_pkg::SCALE_W]
                      : rs_scale_reg[cfcs_pkg::RS_QUIET_LSB +: cfcs_pkg::SCALE_W];
    cfg.c5_decim_m1 = c5_decim_reg;
    cfg.c5_scale    = c5_scale_reg;
    cfg.cf_decim_m1 = cf_decim_reg;
    cfg.cf_phase    = cf_phase_reg;
    cfg.cf_taps     = {1'b0, cf_taps_reg} + 9'h001;
    cfg.cf_offset   = cf_offset_reg;
    cfg.cf_src_chan = src_chan;
    cfg.cf_bypass   = bypass;
    cfg.common_exp  = common_exp;
    cfg.apply_scale = apply_sc;
    cfg.out_fmt     = eff_fmt;
    cfg.out_scale   = oscale;
  end

  // Bank bit only steers host writes, never the running filter
  assign coefficient_memory_bank     = cf_ctrl_reg[cfcs_pkg::CF_BANK_BIT];
  assign active_offset = offset_shadow_reg;
  assign active_phase  = phase_shadow_reg;

  // Configuration registers; reserved locations are not stored, host keeps them zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      interp_reg    <= 9'h000;
      rs_scale_reg  <= 12'h000;
      c5_decim_reg  <= 8'h00;
      c5_scale_reg  <= 5'h00;
      cf_decim_reg  <= 8'h00;
      cf_phase_reg  <= 8'h00;
      cf_taps_reg   <= 8'h00;
      cf_offset_reg <= 8'h00;
      cf_ctrl_reg   <= 11'h000;
      out_ctrl_reg  <= 10'h000;
    end
    else
    begin
      // Wider host data is cut to each register's width
      if (wr_interp) interp_reg    <= host_wdata[8:0];
      if (wr_scale)  rs_scale_reg  <= host_wdata[11:0];
      if (wr_c5dec)  c5_decim_reg  <= host_wdata[7:0];
      if (wr_c5scl)  c5_scale_reg  <= host_wdata[4:0];
      if (wr_cfdec)  cf_decim_reg  <= host_wdata[7:0];
      if (wr_phase)  cf_phase_reg  <= host_wdata[7:0];
      if (wr_taps)   cf_taps_reg   <= host_wdata[7:0];
      if (wr_offset) cf_offset_reg <= host_wdata[7:0];
      if (wr_ctrl)   cf_ctrl_reg   <= host_wdata[10:0];
      if (wr_outc)   out_ctrl_reg  <= host_wdata[9:0];
    end
  end

  // Shadows load at filter start so mid-filter writes do no harm
  // Trade-off: a write lands one filter late, never in the middle of one
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      offset_shadow_reg <= 8'h00;
      phase_shadow_reg  <= 8'h00;
    end
    else if (filter_start)
    begin
      offset_shadow_reg <= cf_offset_reg;
      phase_shadow_reg  <= cf_phase_reg;
    end
  end

  // Source of observed words: comb output when bypassed, else coefficient filter
  wire                 src_valid = bypass ? comb_in_valid : cf_in_valid;
  wire cfcs_pkg::cfcs_iq_s src_word = bypass ? comb_in : cf_in;
  wire                 buf_full  = fill_reg[1];
  wire                 buf_empty = (fill_reg == 2'h0);
  assign comb_in_ready = bypass ? !buf_full : 1'b1;
  assign cf_in_ready   = bypass ? 1'b1 : !buf_full;
  wire push = src_valid && !buf_full;
  wire pop  = !buf_empty && out_ready;
  assign out_valid = !buf_empty;
  assign out_data  = buf_mem[rptr_reg];

  // Two-entry buffer; a stalled receiver back-pressures the source
  // Two entries keep full rate while the sink answers a cycle late
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      fill_reg <= 2'h0;
    end
    else
    begin
      if (push) wptr_reg <= !wptr_reg;
      if (pop)  rptr_reg <= !rptr_reg;
      fill_reg <= 2'(fill_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  // Buffer storage, no reset needed
  always_ff @(posedge clock)
  begin
    if (push) buf_mem[wptr_reg] <= src_word;
  end

  // Self-test sequencer
  wire count_zero = (count_reg == '0);
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      cfcs_pkg::CFCS_ST_IDLE:
      begin
        if (wr_count) state_next = cfcs_pkg::CFCS_ST_RUN;
      end
      cfcs_pkg::CFCS_ST_RUN:
      begin
        // A rewrite of the count restarts at once
        if (wr_count) state_next = cfcs_pkg::CFCS_ST_RUN;
        else if (count_zero) state_next = cfcs_pkg::CFCS_ST_DONE;
      end
      cfcs_pkg::CFCS_ST_DONE:
      begin
        if (wr_count) state_next = cfcs_pkg::CFCS_ST_RUN;
      end
      default:
      begin
        state_next = cfcs_pkg::CFCS_ST_IDLE;
      end
    endcase
  end
  // A zero count leaves the run idle at once, so busy never sticks
  wire running = (state_reg == cfcs_pkg::CFCS_ST_RUN) && !count_zero;
  wire observe = running && pop && !map_mode;
  assign selftest_busy = running;

  // Signature step: shift with feedback, folding in the sample
  function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [15:0] d);
    sig_step = ({s[14:0], 1'b0} ^ (s[15] ? cfcs_pkg::SIG_POLY : 16'h0000)) ^ d;
  endfunction

  // Counter and signatures; a new count write reseeds and restarts
  // A count write wins over an observed word in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= cfcs_pkg::CFCS_ST_IDLE;
      count_reg <= COUNT_W'(cfcs_pkg::COUNT_RST);
      sig_i_reg <= cfcs_pkg::SIG_SEED;
      sig_q_reg <= cfcs_pkg::SIG_SEED;
    end
    else
    begin
      state_reg <= state_next;
      if (wr_count)
      begin
        count_reg <= host_wdata[COUNT_W-1:0];
        sig_i_reg <= cfcs_pkg::SIG_SEED;
        sig_q_reg <= cfcs_pkg::SIG_SEED;
      end
      else if (observe)
      begin
        count_reg <= count_reg - 1'b1;
        sig_i_reg <= sig_step(sig_i_reg, out_data.i);
        sig_q_reg <= sig_step(sig_q_reg, out_data.q);
      end
    end
  end

  // Mapped capture of the latest delivered word
  // The host reads I and Q apart; both halves come from one word
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      map_i_reg <= 16'h0000;
      map_q_reg <= 16'h0000;
    end
    else if (pop && map_mode)
    begin
      map_i_reg <= out_data.i;
      map_q_reg <= out_data.q;
    end
  end

  // Read mux; unmapped and reserved addresses read zero
  // The count reads back the words still to observe
  wire [15:0] st_i = map_mode ? map_i_reg : sig_i_reg;
  wire [15:0] st_q = map_mode ? map_q_reg : sig_q_reg;
  logic [19:0] rmux;
  always_comb
  begin
    rmux = 20'h0_0000;
    case (host_addr)
      cfcs_pkg::ADDR_INTERP_M1: rmux = {11'h000, interp_reg};
      cfcs_pkg::ADDR_RS_SCALE:  rmux = {8'h00, rs_scale_reg};
      cfcs_pkg::ADDR_C5_DECIM:  rmux = {12'h000, c5_decim_reg};
      cfcs_pkg::ADDR_C5_SCALE:  rmux = {15'h0000, c5_scale_reg};
      cfcs_pkg::ADDR_CF_DECIM:  rmux = {12'h000, cf_decim_reg};
      cfcs_pkg::ADDR_CF_PHASE:  rmux = {12'h000, cf_phase_reg};
      cfcs_pkg::ADDR_CF_TAPS:   rmux = {12'h000, cf_taps_reg};
      cfcs_pkg::ADDR_CF_OFFSET: rmux = {12'h000, cf_offset_reg};
      cfcs_pkg::ADDR_CF_CTRL:   rmux = {9'h000, cf_ctrl_reg};
      cfcs_pkg::ADDR_ST_I:      rmux = {4'h0, st_i};
      cfcs_pkg::ADDR_ST_Q:      rmux = {4'h0, st_q};
      cfcs_pkg::ADDR_ST_COUNT:  rmux = 20'(count_reg);
      cfcs_pkg::ADDR_OUT_CTRL:  rmux = {10'h000, out_ctrl_reg};
      default:                  rmux = 20'h0_0000;
    endcase
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg  <= 20'h0_0000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      // Data holds between reads so a late host still sees it
      rvalid_reg <= host_rd;
      if (host_rd) rdata_reg <= rmux;
    end
  end
  assign host_rdata       = rdata_reg;
  assign host_rdata_valid = rvalid_reg;

endmodule

// ===== bench/cfcs_properties.sv
// Checker for cfcs_top: host writes against decoded settings and shadows.
// Assumes it is bound to cfcs_top and sees only that module's ports.
`timescale 1ns/10ps

module cfcs_properties (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic [7:0]          host_addr,
  input wire logic [19:0]         host_wdata,
  input wire logic                host_wr,
  input wire logic                host_rd,
  input wire logic                host_rdata_valid,
  input wire logic                level_indicator_pin,
  input wire logic                agc_path_sel,
  input wire logic                filter_start,
  input wire cfcs_pkg::cfcs_cfg_s cfg,
  input wire logic                coefficient_memory_bank,
  input wire logic [7:0]          active_offset,
  input wire logic                selftest_busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Write strobes per register
  wire w_int  = host_wr && host_addr == cfcs_pkg::ADDR_INTERP_M1;
  wire w_rs   = host_wr && host_addr == cfcs_pkg::ADDR_RS_SCALE;
  wire w_taps = host_wr && host_addr == cfcs_pkg::ADDR_CF_TAPS;
  wire w_ctrl = host_wr && host_addr == cfcs_pkg::ADDR_CF_CTRL;
  wire w_cnt  = host_wr && host_addr == cfcs_pkg::ADDR_ST_COUNT;

  a_read_answer: assert property (host_rdata_valid == $past(host_rd)) else $error("read answer not one cycle");
  a_interp_hold: assert property (w_int |=> cfg.interp_m1 == $past(host_wdata[8:0])) else $error("interp field wrong");
  a_exp_bits: assert property (w_rs |=> cfg.exp_invert == $past(host_wdata[11]) && cfg.exp_weight == $past(host_wdata[10])) else $error("exponent bits wrong");
  a_scale_pick: assert property (w_rs |=> cfg.rs_scale == (level_indicator_pin ? $past(host_wdata[4:0]) : $past(host_wdata[9:5]))) else $error("scale pick wrong");
  a_taps_plus: assert property (w_taps |=> cfg.cf_taps == {1'b0, $past(host_wdata[7:0])} + 9'h001) else $error("tap count wrong");
  a_offset_shadow: assert property (!filter_start |=> $stable(active_offset)) else $error("offset moved without start");
  a_ctrl_bits: assert property (w_ctrl |=> coefficient_memory_bank == $past(host_wdata[8]) && cfg.cf_bypass == $past(host_wdata[10])) else $error("control bits wrong");
  a_agc_fixed: assert property (agc_path_sel |-> cfg.out_fmt == cfcs_pkg::FMT_FIXED) else $error("gain path not fixed");
  a_count_start: assert property (w_cnt |=> selftest_busy == ($past(host_wdata) != 20'h0_0000)) else $error("self-test start wrong");
endmodule

bind cfcs_top cfcs_properties cfcs_properties_i (.clock(clock), .rst(rst), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
  .host_rdata_valid(host_rdata_valid), .level_indicator_pin(level_indicator_pin),
  .agc_path_sel(agc_path_sel), .filter_start(filter_start), .cfg(cfg), .coefficient_memory_bank(coefficient_memory_bank),
  .active_offset(active_offset), .selftest_busy(selftest_busy));

// ===== bench/cfcs_host_model.sv
// Host model: drives the channel register port one access at a time.
// Assumes strobes are taken at a rising edge and read data follows one cycle later.
`timescale 1ns/10ps

module cfcs_host_model (
  input wire logic         clock,
  output logic [7:0]       host_addr,
  output logic [19:0]      host_wdata,
  output logic             host_wr,
  output logic             host_rd,
  input wire logic [19:0]  host_rdata,
  input wire logic         host_rdata_valid
);
  initial
  begin
    host_addr = 8'h00;
    host_wdata = 20'h0_0000;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // Data inverted once released so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    @(posedge clock);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clock);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask
  // Reserved places only ever see zero
  task automatic wr_rsvd(input logic [7:0] a);
    wr(a, 20'h0_0000);
  endtask
  task automatic rd(input logic [7:0] a, output logic [19:0] v);
    @(posedge clock);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    @(posedge clock);
    v = (host_rdata_valid === 1'b1) ? host_rdata : 'x;
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for cfcs_top: registers, shadows, output buffer, self-test.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps

module testbench;
  typedef struct packed {
    logic [7:0]  a;
    logic [19:0] d;
    logic [19:0] e;
  } cfcs_row_s;
  localparam int CHAN = 6;
  logic clock, rst, level_indicator_pin, agc_path_sel, filter_start;
  logic comb_in_valid, cf_in_valid, out_ready, comb_in_ready, cf_in_ready;
  logic out_valid, selftest_busy, coefficient_memory_bank, host_wr, host_rd, host_rdata_valid;
  logic [7:0] host_addr, active_offset, active_phase;
  logic [19:0] host_wdata, host_rdata, v;
  logic [15:0] si, sq;
  cfcs_pkg::cfcs_iq_s comb_in, cf_in, out_data;
  cfcs_pkg::cfcs_iq_s got[$];
  cfcs_pkg::cfcs_cfg_s cfg;
  int failures, checks, k;
  cfcs_row_s rows [10] = '{'{8'h91, 20'hF_FFFF, 20'h0_01FF}, '{8'h92, 20'hF_FFFF, 20'h0_0FFF},
    '{8'h94, 20'hF_FF1F, 20'h0_001F}, '{8'h95, 20'hF_FFFF, 20'h0_001F},
    '{8'hA0, 20'hF_FFFF, 20'h0_00FF}, '{8'hA1, 20'hF_FFFF, 20'h0_00FF},
    '{8'hA2, 20'hF_FFFF, 20'h0_00FF}, '{8'hA3, 20'hF_FFFF, 20'h0_00FF},
    '{8'hA4, 20'hF_FFFF, 20'h0_07FF}, '{8'h98, 20'hF_FFFF, 20'h0_0000}};

  cfcs_top #(.CHANNEL(CHAN)) cfcs_top_i (.clock(clock), .rst(rst), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid), .level_indicator_pin(level_indicator_pin),
    .agc_path_sel(agc_path_sel), .filter_start(filter_start), .comb_in_valid(comb_in_valid),
    .comb_in_ready(comb_in_ready), .comb_in(comb_in), .cf_in_valid(cf_in_valid),
    .cf_in_ready(cf_in_ready), .cf_in(cf_in), .cfg(cfg), .coefficient_memory_bank(coefficient_memory_bank),
    .active_offset(active_offset), .active_phase(active_phase), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data), .selftest_busy(selftest_busy));
  cfcs_host_model cfcs_host_model_i (.clock(clock), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rdata_valid(host_rdata_valid));

  // Clock at 8 ns
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Popped words collected for ordering checks
  always @(posedge clock)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back(out_data);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Offers one word and holds it until the selected source takes it
  task automatic push(input logic sel, input cfcs_pkg::cfcs_iq_s w);
    int n;
    n = 0;
    @(posedge clock);
    comb_in <= w;
    cf_in <= w;
    comb_in_valid <= sel;
    cf_in_valid <= !sel;
    @(posedge clock);
    while (!(sel ? comb_in_ready : cf_in_ready) && n < 50)
    begin
      n++;
      @(posedge clock);
    end
    if (n == 50)
      failures++;
    comb_in_valid <= 1'b0;
    cf_in_valid <= 1'b0;
    comb_in <= ~w;
    cf_in <= ~w;
  endtask
  function automatic logic [15:0] sig(input logic [15:0] s, input logic [15:0] d);
    return ({s[14:0], 1'b0} ^ (s[15] ? cfcs_pkg::SIG_POLY : 16'h0000)) ^ d;
  endfunction

  // Watchdog sized well past the whole sequence
  initial
  begin
    #200_000;
    failures++;
    stop_test;
  end

  initial
  begin
    {rst, level_indicator_pin, agc_path_sel, filter_start} = 4'h8;
    {comb_in_valid, cf_in_valid, out_ready} = 3'h0;
    comb_in = 32'h0000_0000;
    cf_in = 32'h0000_0000;
    failures = 0;
    checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_CF_CTRL, v);
    check(v, 32'h0000_0000);
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_I, v);
    check(v, 32'h0000_FFFF);
    check({out_valid, selftest_busy}, 32'h0000_0000);
    // Register table, unmapped place last
    for (k = 0; k < 10; k++)
    begin
      cfcs_host_model_i.wr(rows[k].a, rows[k].d);
      cfcs_host_model_i.rd(rows[k].a, v);
      check(v, rows[k].e);
    end
    cfcs_host_model_i.wr_rsvd(8'h93);
    cfcs_host_model_i.rd(8'h93, v);
    check(v, 32'h0000_0000);
    #1 check(cfg.cf_taps, 32'h0000_0100);
    // Both scale halves under the level pin
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_RS_SCALE, 20'h0_0955);
    #1 check({cfg.exp_invert, cfg.exp_weight, cfg.rs_scale}, 32'h0000_004A);
    @(posedge clock);
    level_indicator_pin <= 1'b1;
    #1 check(cfg.rs_scale, 32'h0000_0015);
    // Every format code, with and without forced scale and other source
    for (k = 0; k < 8; k++)
    begin
      @(posedge clock);
      agc_path_sel <= (k == 3);
      cfcs_host_model_i.wr(cfcs_pkg::ADDR_CF_CTRL, (k[0] << 9) | (k[2] << 8) | (k[1] << 7)
        | (k[2] << 6) | (k[1:0] << 4) | 20'h0_0009);
      #1 check(cfg.out_fmt == cfcs_pkg::FMT_FIXED, (k[1:0] == 0 || k == 3));
      check(cfg.apply_scale, (k[1:0] == 0 || k == 3 || k[2]));
      check(coefficient_memory_bank, k[2]);
      check({cfg.common_exp, cfg.out_scale}, {k[1], 4'h9});
      check(cfg.cf_src_chan, k[0] ? 32'd5 : CHAN);
    end
    // Shadows wait for a filter start
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_CF_OFFSET, 20'h0_0033);
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_CF_PHASE, 20'h0_0005);
    check(active_offset, 32'h0000_0000);
    filter_start <= 1'b1;
    @(posedge clock);
    filter_start <= 1'b0;
    #1 check({active_offset, active_phase}, 32'h0000_3305);
    // Self-test over two words while the sink stalls and the buffer fills
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_CF_CTRL, 20'h0_0000);
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_OUT_CTRL, 20'h0_0000);
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_ST_COUNT, 20'h0_0002);
    #1 check(selftest_busy, 32'h0000_0001);
    push(1'b0, 32'h1234_8001);
    push(1'b0, 32'hBEEF_0F0F);
    fork
      push(1'b0, 32'h5555_AAAA);
      begin
        repeat (3) @(posedge clock);
        check({cf_in_ready, comb_in_ready}, 32'h0000_0001);
        out_ready <= 1'b1;
      end
    join
    repeat (4) @(posedge clock);
    check(got.size(), 32'd3);
    check(got[0], 32'h1234_8001);
    check(got[1], 32'hBEEF_0F0F);
    si = sig(sig(cfcs_pkg::SIG_SEED, 16'h1234), 16'hBEEF);
    sq = sig(sig(cfcs_pkg::SIG_SEED, 16'h8001), 16'h0F0F);
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_I, v);
    check(v, si);
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_Q, v);
    check(v, sq);
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_COUNT, v);
    check({v, selftest_busy}, 32'h0000_0000);
    // Bypassed comb word read back through the mapped registers
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_CF_CTRL, 20'h0_0400);
    cfcs_host_model_i.wr(cfcs_pkg::ADDR_OUT_CTRL, 20'h0_0200);
    push(1'b1, 32'hC0DE_7E57);
    repeat (3) @(posedge clock);
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_I, v);
    check(v, 32'h0000_C0DE);
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_Q, v);
    check(v, 32'h0000_7E57);
    // Reset after the self-test has finished drops mapping and settings
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cfcs_host_model_i.rd(cfcs_pkg::ADDR_ST_I, v);
    check(v, 32'h0000_FFFF);
    #1 check(cfg.cf_taps, 32'h0000_0001);
    stop_test;
  end
endmodule
